//--- verilog/umt_pkg.sv
// Constants and carrier types shared by the UART mode-two block.
// Assumes a 32-bit AHB-Lite register bus and one 50 MHz clock.
package umt_pkg;
  // Register byte offsets.
  localparam logic [4:0] UMT_OFF_MODE = 5'h00;
  localparam logic [4:0] UMT_OFF_CTRL = 5'h04;
  localparam logic [4:0] UMT_OFF_STAT = 5'h08;
  localparam logic [4:0] UMT_OFF_TXD = 5'h0c;
  localparam logic [4:0] UMT_OFF_OPB = 5'h10;
  localparam logic [4:0] UMT_OFF_RXD = 5'h14;
  localparam logic [4:0] UMT_OFF_DIV = 5'h18;
  // Field positions.
  localparam int UMT_M2_LOOP_HI = 7;
  localparam int UMT_M2_LOOP_LO = 6;
  localparam int UMT_M2_AUTO_RTS = 5;
  localparam int UMT_M2_CTS_GATE = 4;
  localparam int UMT_M2_STOP_HI = 3;
  localparam int UMT_M2_STOP_LO = 0;
  localparam int UMT_M1_LEN_HI = 1;
  localparam int UMT_M1_LEN_LO = 0;
  localparam int UMT_CTRL_PTR_RST = 0;
  localparam int UMT_CTRL_TX_EN = 1;
  localparam int UMT_CTRL_RX_RTS = 2;
  localparam int UMT_CTRL_MODEM = 3;
  localparam int UMT_OPB_RTS = 0;
  // Reset values.
  localparam logic [7:0] UMT_MODE_RESET = 8'h00;
  localparam logic [3:0] UMT_CTRL_RESET = 4'h0;
  localparam logic [15:0] UMT_DIV_RESET = 16'h001a;
  // Timing in sixteenths of a bit.
  localparam logic [3:0] UMT_SIXT_LAST = 4'hf;
  localparam logic [3:0] UMT_HALF_LAST = 4'h7;
  localparam logic [4:0] UMT_STOP_BASE_SHORT = 5'h09;
  localparam logic [4:0] UMT_STOP_BASE_LONG = 5'h11;
  localparam logic [1:0] UMT_LEN_FIVE = 2'h0;

  typedef enum logic [1:0] {
    UMT_LOOP_NORMAL = 2'b00,
    UMT_LOOP_ECHO = 2'b01,
    UMT_LOOP_LOCAL = 2'b10,
    UMT_LOOP_REMOTE = 2'b11
  } umt_loop_t;

  typedef enum logic [2:0] {
    UMT_TX_IDLE = 3'b000,
    UMT_TX_START = 3'b001,
    UMT_TX_DATA = 3'b010,
    UMT_TX_STOP = 3'b011,
    UMT_TX_RTSW = 3'b100
  } umt_tx_state_t;

  typedef enum logic [1:0] {
    UMT_RX_IDLE = 2'b00,
    UMT_RX_START = 2'b01,
    UMT_RX_DATA = 2'b10,
    UMT_RX_STOP = 2'b11
  } umt_rx_state_t;

  // One pending AHB data phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
  } umt_dphase_t;

  // One character waiting for the transmitter.
  typedef struct packed {
    logic [7:0] data;
  } umt_txword_t;
endpackage

//--- verilog/umt_uart.sv
// UART channel with two mode registers behind a shared address, looping,
// automatic request-to-send negation and clear-to-send gating.
// Assumes one AHB-Lite master, hready fed back from hreadyout, and
// asynchronous rxd and cts_n pins from a remote UART or modem.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: Mode-one access advances pointer to mode two.
// R2: Mode-two access leaves the pointer unchanged.
// R3: Bits 7-6 select normal, echo, local, remote.
// R4: Auto request-to-send off: transmitter leaves it.
// R5: Auto mode clears request-to-send bit after idle.
// R6: Receiver plus transmitter control disables both.
// R7: Clear-to-send gating overrides auto request-to-send.
// R8: Send only while clear-to-send asserted; idle high.
// R9: Started character finishes whatever clear-to-send does.
// R10: Modem operation ignores both transmitter control bits.
// R11: Stop length in sixteenth-bit steps from code.
// R12: Receiver checks only first stop bit centre.
module umt_uart
  import umt_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd,
  output logic rts_n
);

  function automatic logic [4:0] stop_sixteenths(input logic [3:0] code, input logic [1:0] len);
    logic [4:0] base;
    base = (code[3] || len == UMT_LEN_FIVE) ? UMT_STOP_BASE_LONG : UMT_STOP_BASE_SHORT;
    return base + {1'b0, code};
  endfunction

  function automatic logic [2:0] last_bit(input logic [1:0] len);
    return 3'h4 + {1'b0, len};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  umt_dphase_t dp_r;
  logic rd_done_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic ptr_r;
  logic [7:0] mode_one_r;
  logic [7:0] mode_two_r;
  logic [3:0] ctrl_r;
  logic rts_bit_r;
  logic [15:0] div_r;
  logic [15:0] div_cnt_r;
  logic tick;
  logic [1:0] rxd_sync_r;
  logic [1:0] cts_sync_r;
  logic rxd_s;
  logic cts_s;
  logic accept;
  logic full;
  logic stall;
  logic rd_cap;
  logic wr_do;
  logic mode_acc;
  umt_txword_t buf_mem_r [BUF_DEPTH];
  logic buf_wp_r;
  logic buf_rp_r;
  logic [1:0] buf_cnt_r;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  umt_tx_state_t tx_st_r;
  logic [3:0] tx_cnt_r;
  logic [4:0] tx_stop_cnt_r;
  logic [2:0] tx_idx_r;
  logic [7:0] tx_sh_r;
  logic [1:0] tx_len_r;
  logic tx_line_r;
  logic tx_end;
  logic rts_clr;
  logic auto_rts_en;
  logic cts_en;
  logic cts_block;
  umt_rx_state_t rx_st_r;
  logic [3:0] rx_cnt_r;
  logic [2:0] rx_idx_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_data_r;
  logic rx_valid_r;
  logic rx_ferr_r;
  logic rx_done;
  logic line_rx;
  umt_loop_t loop_sel;
  logic txd_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_sync_r <= 2'h3;
      cts_sync_r <= 2'h3;
    end else if (ce) begin
      rxd_sync_r <= {rxd_sync_r[0], rxd};
      cts_sync_r <= {cts_sync_r[0], cts_n};
    end
  end
  assign rxd_s = rxd_sync_r[1];
  assign cts_s = !cts_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave. Reads take one wait state so that read side effects and
  // read data are taken in one cycle, the cycle after any write landing before them.
  assign accept = hsel && hready && htrans[1] && ce;
  assign full = !push_ready;
  assign stall = !ce || (dp_r.valid && !dp_r.write && !rd_done_r) ||
                 (dp_r.valid && dp_r.write && dp_r.addr == UMT_OFF_TXD && full);
  assign hreadyout = !stall;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign rd_cap = ce && dp_r.valid && !dp_r.write && !rd_done_r;
  assign wr_do = dp_r.valid && dp_r.write && hreadyout;
  assign mode_acc = (rd_cap || wr_do) && dp_r.addr == UMT_OFF_MODE;
  assign push_valid = wr_do && dp_r.addr == UMT_OFF_TXD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_r <= '0;
      rd_done_r <= 1'b0;
    end else if (ce) begin
      rd_done_r <= rd_cap;
      if (accept) begin
        dp_r <= '{valid: 1'b1, write: hwrite, addr: {haddr[4:2], 2'b00}};
      end else if (hreadyout) begin
        dp_r <= '0;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (dp_r.addr)
      UMT_OFF_MODE: rd_mux[7:0] = ptr_r ? mode_two_r : mode_one_r;
      UMT_OFF_CTRL: rd_mux[3:0] = ctrl_r;
      UMT_OFF_STAT: rd_mux[6:0] = {rx_ferr_r, rx_valid_r, cts_s, rts_bit_r, ptr_r,
                                   tx_st_r == UMT_TX_IDLE, push_ready};
      UMT_OFF_OPB: rd_mux[UMT_OPB_RTS] = rts_bit_r;
      UMT_OFF_RXD: rd_mux[7:0] = rx_data_r;
      UMT_OFF_DIV: rd_mux[15:0] = div_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_cap) begin
      hrdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode pointer and registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_r <= 1'b0;
    end else if (ce) begin
      if (wr_do && dp_r.addr == UMT_OFF_CTRL && hwdata[UMT_CTRL_PTR_RST]) begin
        ptr_r <= 1'b0;
      end else if (mode_acc && !ptr_r) begin
        ptr_r <= 1'b1; // R1
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_one_r <= UMT_MODE_RESET;
      mode_two_r <= UMT_MODE_RESET;
      ctrl_r <= UMT_CTRL_RESET;
      div_r <= UMT_DIV_RESET;
    end else if (ce && wr_do) begin
      case (dp_r.addr)
        UMT_OFF_MODE: begin
          if (ptr_r) begin
            mode_two_r <= hwdata[7:0];
          end else begin
            mode_one_r <= hwdata[7:0];
          end
        end
        UMT_OFF_CTRL: ctrl_r <= {hwdata[3:1], 1'b0};
        UMT_OFF_DIV: div_r <= hwdata[15:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Software writing the port bit wins over the automatic clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_bit_r <= 1'b0;
    end else if (ce) begin
      if (wr_do && dp_r.addr == UMT_OFF_OPB) begin
        rts_bit_r <= hwdata[UMT_OPB_RTS];
      end else if (rts_clr) begin
        rts_bit_r <= 1'b0; // R5
      end
    end
  end
  assign rts_n = !rts_bit_r;

  // Receiver request-to-send control with transmitter control is not allowed,
  // and clear-to-send gating takes precedence; modem operation drops both.
  assign auto_rts_en = mode_two_r[UMT_M2_AUTO_RTS] && !ctrl_r[UMT_CTRL_RX_RTS] && // R6
                       !mode_two_r[UMT_M2_CTS_GATE] && !ctrl_r[UMT_CTRL_MODEM]; // R7 R10
  assign cts_en = mode_two_r[UMT_M2_CTS_GATE] && !ctrl_r[UMT_CTRL_MODEM]; // R10
  assign cts_block = cts_en && !cts_s; // R8

  ////////////////////////////////////////////////////////////////////////////////
  // Sixteenth-bit tick.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_r <= 16'h0000;
    end else if (ce) begin
      div_cnt_r <= (div_cnt_r == 16'h0000) ? div_r : div_cnt_r - 16'h0001;
    end
  end
  assign tick = ce && div_cnt_r == 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry transmit buffer; a full buffer stalls the bus write.
  assign push_ready = buf_cnt_r != 2'(BUF_DEPTH);
  assign pop_valid = buf_cnt_r != 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      buf_cnt_r <= 2'h0;
    end else if (ce) begin
      if (push_valid && push_ready) begin
        buf_wp_r <= !buf_wp_r;
      end
      if (pop_valid && pop_ready) begin
        buf_rp_r <= !buf_rp_r;
      end
      buf_cnt_r <= buf_cnt_r + 2'(push_valid && push_ready) - 2'(pop_valid && pop_ready);
    end
  end

  always_ff @(posedge hclk) begin
    if (ce && push_valid && push_ready) begin
      buf_mem_r[buf_wp_r] <= '{data: hwdata[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  assign pop_ready = ce && ctrl_r[UMT_CTRL_TX_EN] && !cts_block &&
                     (tx_st_r == UMT_TX_IDLE || (tx_st_r == UMT_TX_STOP && tx_end)); // R8
  assign tx_end = tick && (tx_st_r == UMT_TX_STOP ? tx_stop_cnt_r == 5'h00 : tx_cnt_r == 4'h0);
  // Control dropped while waiting out the last bit time leaves the port bit alone.
  assign rts_clr = ce && auto_rts_en && tx_st_r == UMT_TX_RTSW && tx_end && !pop_valid; // R5 R4

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_r <= UMT_TX_IDLE;
      tx_cnt_r <= 4'h0;
      tx_stop_cnt_r <= 5'h00;
      tx_idx_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_len_r <= 2'h0;
      tx_line_r <= 1'b1;
    end else if (ce) begin
      if (pop_valid && pop_ready) begin
        tx_st_r <= UMT_TX_START;
        tx_cnt_r <= UMT_SIXT_LAST;
        tx_sh_r <= buf_mem_r[buf_rp_r].data;
        tx_len_r <= mode_one_r[UMT_M1_LEN_HI:UMT_M1_LEN_LO];
        tx_line_r <= 1'b0;
      end else if (tick) begin
        tx_cnt_r <= tx_cnt_r - 4'h1;
        case (tx_st_r)
          UMT_TX_IDLE: tx_line_r <= 1'b1;
          UMT_TX_START: begin // R9
            if (tx_end) begin
              tx_st_r <= UMT_TX_DATA;
              tx_idx_r <= 3'h0;
              tx_line_r <= tx_sh_r[0];
            end
          end
          UMT_TX_DATA: begin
            if (tx_end && tx_idx_r == last_bit(tx_len_r)) begin
              tx_st_r <= UMT_TX_STOP;
              tx_line_r <= 1'b1;
              tx_stop_cnt_r <= stop_sixteenths(mode_two_r[UMT_M2_STOP_HI:UMT_M2_STOP_LO],
                                               tx_len_r) - 5'h01; // R11
            end else if (tx_end) begin
              tx_idx_r <= tx_idx_r + 3'h1;
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              tx_line_r <= tx_sh_r[1];
            end
          end
          UMT_TX_STOP: begin
            tx_stop_cnt_r <= tx_stop_cnt_r - 5'h01;
            if (tx_end) begin
              tx_st_r <= (auto_rts_en && !pop_valid) ? UMT_TX_RTSW : UMT_TX_IDLE; // R5
              tx_cnt_r <= UMT_SIXT_LAST;
            end
          end
          UMT_TX_RTSW: begin
            if (tx_end) begin
              tx_st_r <= UMT_TX_IDLE;
            end
          end
          default: tx_st_r <= UMT_TX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Looping. Echo and remote loop send the received line back out.
  assign loop_sel = umt_loop_t'(mode_two_r[UMT_M2_LOOP_HI:UMT_M2_LOOP_LO]);
  assign line_rx = (loop_sel == UMT_LOOP_LOCAL) ? tx_line_r :
                   (loop_sel == UMT_LOOP_REMOTE) ? 1'b1 : rxd_s; // R3

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_r <= 1'b1;
    end else if (ce) begin
      case (loop_sel)
        UMT_LOOP_NORMAL: txd_r <= tx_line_r; // R3
        UMT_LOOP_LOCAL: txd_r <= 1'b1;
        default: txd_r <= rxd_s;
      endcase
    end
  end
  assign txd = txd_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver. A character ends at the centre of its first stop bit, so a longer
  // programmed stop length never delays the next start search.
  assign rx_done = tick && rx_st_r == UMT_RX_STOP && rx_cnt_r == 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_r <= UMT_RX_IDLE;
      rx_cnt_r <= 4'h0;
      rx_idx_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_data_r <= 8'h00;
      rx_ferr_r <= 1'b0;
    end else if (ce) begin
      if (rx_st_r == UMT_RX_IDLE) begin
        if (!line_rx) begin
          rx_st_r <= UMT_RX_START;
          rx_cnt_r <= UMT_HALF_LAST;
        end
      end else if (tick && rx_cnt_r != 4'h0) begin
        rx_cnt_r <= rx_cnt_r - 4'h1;
      end else if (tick) begin
        rx_cnt_r <= UMT_SIXT_LAST;
        case (rx_st_r)
          UMT_RX_START: begin
            rx_st_r <= line_rx ? UMT_RX_IDLE : UMT_RX_DATA;
            rx_idx_r <= 3'h0;
          end
          UMT_RX_DATA: begin
            rx_sh_r <= {line_rx, rx_sh_r[7:1]};
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_idx_r == last_bit(mode_one_r[UMT_M1_LEN_HI:UMT_M1_LEN_LO])) begin
              rx_st_r <= UMT_RX_STOP;
            end
          end
          UMT_RX_STOP: begin
            rx_st_r <= UMT_RX_IDLE; // R12
            rx_ferr_r <= !line_rx;
            rx_data_r <= rx_sh_r >> (2'h3 - mode_one_r[UMT_M1_LEN_HI:UMT_M1_LEN_LO]);
          end
          default: rx_st_r <= UMT_RX_IDLE;
        endcase
      end
    end
  end

  // A character landing in the cycle the data register is read keeps the flag set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_valid_r <= 1'b0;
    end else if (ce) begin
      if (rx_done) begin
        rx_valid_r <= 1'b1;
      end else if (rd_cap && dp_r.addr == UMT_OFF_RXD) begin
        rx_valid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_PTR_ADV: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (mode_acc && !ptr_r && !(wr_do && dp_r.addr == UMT_OFF_CTRL)) |=> ptr_r)
    else $error("mode pointer did not advance");
  AST_PTR_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (mode_acc && ptr_r) |=> ptr_r)
    else $error("mode-two access moved the pointer");
  AST_LOOP_LOCAL: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (ce && loop_sel == UMT_LOOP_LOCAL) |=> txd)
    else $error("local loop drove the line");
  AST_LOOP_ECHO: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (ce && loop_sel == UMT_LOOP_ECHO) |=> txd == $past(rxd_s))
    else $error("echo did not follow the receive line");
  AST_RTS_OFF: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    ($fell(rts_bit_r) && !$past(wr_do && dp_r.addr == UMT_OFF_OPB)) |-> $past(auto_rts_en))
    else $error("request-to-send cleared without automatic control");
  AST_RTS_ONE_BIT: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    rts_clr |-> (tx_st_r == UMT_TX_RTSW && tx_cnt_r == 4'h0 && !pop_valid))
    else $error("request-to-send cleared at the wrong time");
  AST_RTS_BOTH: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    ctrl_r[UMT_CTRL_RX_RTS] |-> !auto_rts_en)
    else $error("both sides hold request-to-send control");
  AST_CTS_WINS: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    mode_two_r[UMT_M2_CTS_GATE] |-> !auto_rts_en)
    else $error("clear-to-send did not govern the transmitter");
  AST_CTS_GATE: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (tx_st_r == UMT_TX_IDLE && cts_block) |=> tx_st_r == UMT_TX_IDLE && tx_line_r)
    else $error("character started while clear-to-send negated");
  AST_CTS_NO_ABORT: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    (ce && tx_st_r == UMT_TX_DATA && !tx_end) |=> tx_st_r == UMT_TX_DATA)
    else $error("character broken off mid-frame");
  AST_MODEM: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    ctrl_r[UMT_CTRL_MODEM] |-> !auto_rts_en && !cts_en)
    else $error("transmitter control bits acted in modem operation");
  AST_STOP_LEN: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    $rose(tx_st_r == UMT_TX_STOP) |->
      tx_stop_cnt_r == stop_sixteenths(mode_two_r[3:0], tx_len_r) - 5'h01)
    else $error("stop length differs from the code");
  AST_RX_FIRST_STOP: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    rx_done |=> rx_st_r == UMT_RX_IDLE && rx_valid_r)
    else $error("receiver waited past the first stop bit");

endmodule // umt_uart

`default_nettype wire

//--- test/umt_peer.sv
// Remote UART partner: sends characters on rxd, receives them from txd, drives cts_n.
// Assumes the block runs at 16 clocks per bit, with the divider written to 0.
`timescale 1ns/1ps
`default_nettype none
module umt_peer (
  input wire logic hclk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  logic cts_q = 1'b0;
  int nbits = 8;
  int cyc = 0;
  logic [7:0] got[$];
  int st[$];
  logic [7:0] d;
  assign cts_n = cts_q;
  initial rxd = 1'b1;
  always @(posedge hclk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  // The receiver re-arms one clock into the stop bit, so the shortest stop is not missed.
  initial begin
    forever begin
      @(negedge txd);
      repeat (8) @(posedge hclk);
      if (txd === 1'b0) begin
        st.push_back(cyc);
        d = 8'h00;
        for (int i = 0; i < nbits; i++) begin
          repeat (16) @(posedge hclk);
          d[i] = txd;
        end
        got.push_back(d);
        repeat (9) @(posedge hclk);
      end
    end
  end
  task automatic send(input logic [7:0] v);
    rxd <= 1'b0;
    repeat (16) @(posedge hclk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= v[i];
      repeat (16) @(posedge hclk);
    end
    rxd <= 1'b1;
    repeat (16) @(posedge hclk);
  endtask
endmodule // umt_peer
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench: AHB-Lite register tasks and serial scenarios for the UART.
// Assumes umt_peer on the serial pins and hready fed back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import umt_pkg::*;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, txd, rts_n, rxd, cts_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int error_cnt = 0;
  int total_checks = 0;
  int k;
  logic [7:0] sl_m1 [0:4] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h00};
  logic [7:0] sl_m2 [0:4] = '{8'h00, 8'h07, 8'h08, 8'h0f, 8'h00};
  int sl_len [0:4] = '{153, 160, 169, 176, 113};
  logic [7:0] ar_m2 [0:4] = '{8'h27, 8'h07, 8'h27, 8'h27, 8'h37};
  logic [7:0] ar_c [0:4] = '{8'h02, 8'h02, 8'h06, 8'h0a, 8'h02};
  logic ar_clr [0:4] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  assign hready = hreadyout;
  umt_uart #(.BUF_DEPTH(2)) dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));
  umt_peer peer_u (.hclk(hclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // A transmit write may stall for a whole frame, so the bound is generous.
  task automatic hold();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {27'h0, a};
    hwrite <= w;
    hold();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    hold();
    r = hrdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic wait_got(input int n);
    int t;
    t = 0;
    while (peer_u.got.size() < n && t < 3000) begin
      @(posedge hclk);
      t++;
    end
    if (t >= 3000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic cfg(input logic [7:0] m1, input logic [7:0] m2, input logic [7:0] c);
    wr(UMT_OFF_CTRL, {24'h0, c | 8'h01});
    wr(UMT_OFF_MODE, {24'h0, m1});
    wr(UMT_OFF_MODE, {24'h0, m2});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    chk({29'h0, hresp, rts_n, txd}, 32'h3);
    rchk(UMT_OFF_MODE, 32'hffffffff, 32'h0);
    rchk(UMT_OFF_STAT, 32'h4, 32'h4);
    wr(UMT_OFF_MODE, 32'hd7);
    rchk(UMT_OFF_MODE, 32'hffffffff, 32'hd7);
    rchk(UMT_OFF_MODE, 32'hffffffff, 32'hd7);
    rchk(UMT_OFF_STAT, 32'h4, 32'h4);
    wr(UMT_OFF_CTRL, 32'h1);
    rchk(UMT_OFF_STAT, 32'h4, 32'h0);
    wr(UMT_OFF_MODE, 32'h2);
    rchk(UMT_OFF_MODE, 32'hffffffff, 32'hd7);
    rchk(UMT_OFF_DIV, 32'hffffffff, {16'h0, UMT_DIV_RESET});
    rchk(5'h1c, 32'hffffffff, 32'h0);
    wr(UMT_OFF_DIV, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      cfg(sl_m1[i], sl_m2[i], 8'h02);
      peer_u.nbits = (sl_m1[i] == 8'h00) ? 5 : 8;
      k = peer_u.got.size();
      wr(UMT_OFF_TXD, 32'h55);
      wr(UMT_OFF_TXD, 32'haa);
      wait_got(k + 2);
      chk(32'(peer_u.st[k + 1] - peer_u.st[k]), 32'(sl_len[i]));
      chk({24'h0, peer_u.got[k + 1]}, (sl_m1[i] == 8'h00) ? 32'h0a : 32'haa);
    end
    peer_u.nbits = 8;
    $display("test stop length done");
    for (int i = 0; i < 5; i++) begin
      cfg(8'h03, ar_m2[i], ar_c[i]);
      wr(UMT_OFF_OPB, 32'h1);
      k = peer_u.got.size();
      wr(UMT_OFF_TXD, 32'h3c);
      wait_got(k + 1);
      repeat (30) @(posedge hclk);
      chk({31'h0, rts_n}, 32'h0);
      repeat (20) @(posedge hclk);
      chk({31'h0, rts_n}, {31'h0, ar_clr[i]});
    end
    $display("test auto rts done");
    cfg(8'h03, 8'h17, 8'h02);
    peer_u.cts_q <= 1'b1;
    k = peer_u.got.size();
    wr(UMT_OFF_TXD, 32'h11);
    wr(UMT_OFF_TXD, 32'h22);
    repeat (100) @(posedge hclk);
    chk({31'h0, txd}, 32'h1);
    rchk(UMT_OFF_STAT, 32'h1, 32'h0);
    fork
      wr(UMT_OFF_TXD, 32'h33);
      begin
        repeat (5) @(posedge hclk);
        peer_u.cts_q <= 1'b0;
        for (int t = 0; t < 500 && peer_u.st.size() <= k; t++) @(posedge hclk);
        repeat (20) @(posedge hclk);
        peer_u.cts_q <= 1'b1;
      end
    join
    wait_got(k + 1);
    chk({24'h0, peer_u.got[k]}, 32'h11);
    repeat (200) @(posedge hclk);
    chk(32'(peer_u.got.size()), 32'(k + 1));
    peer_u.cts_q <= 1'b0;
    wait_got(k + 3);
    chk({24'h0, peer_u.got[k + 2]}, 32'h33);
    cfg(8'h03, 8'h17, 8'h0a);
    peer_u.cts_q <= 1'b1;
    k = peer_u.got.size();
    wr(UMT_OFF_TXD, 32'h44);
    wait_got(k + 1);
    chk({24'h0, peer_u.got[k]}, 32'h44);
    peer_u.cts_q <= 1'b0;
    $display("test cts gate done");
    cfg(8'h03, 8'h07, 8'h02);
    peer_u.send(8'h5a);
    rchk(UMT_OFF_STAT, 32'h20, 32'h20);
    rchk(UMT_OFF_RXD, 32'hff, 32'h5a);
    cfg(8'h03, 8'h47, 8'h02);
    k = peer_u.got.size();
    peer_u.send(8'h3c);
    wait_got(k + 1);
    chk({24'h0, peer_u.got[k]}, 32'h3c);
    cfg(8'h03, 8'h87, 8'h02);
    k = peer_u.got.size();
    wr(UMT_OFF_TXD, 32'ha5);
    repeat (250) @(posedge hclk);
    rchk(UMT_OFF_RXD, 32'hff, 32'ha5);
    chk(32'(peer_u.got.size()), 32'(k));
    cfg(8'h03, 8'hc7, 8'h02);
    k = peer_u.got.size();
    peer_u.send(8'h96);
    wait_got(k + 1);
    chk({24'h0, peer_u.got[k]}, 32'h96);
    rchk(UMT_OFF_STAT, 32'h20, 32'h0);
    $display("test loop modes done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
